// ===== design/rpc_pkg.sv
package rpc_pkg;
   // Clock control register fields
   localparam int CC_CLKOUT_LSB = 0;
   localparam int CC_CLKOUT_W = 3;
   localparam int CC_HZ50 = 3;
   localparam int CC_XSEL_LSB = 4;
   localparam int CC_LINE = 6;
   localparam int CC_START = 7;
   // Interrupt control register fields
   localparam int IC_PER_LSB = 0;
   localparam int IC_PER_W = 4;
   localparam int IC_ALARM = 4;
   localparam int IC_PSENSE = 5;
   localparam int IC_PDOWN = 6;
   localparam int IC_WDOG = 7;
   // Status register fields
   localparam int ST_CLOCK = 0;
   localparam int ST_ALARM = 1;
   localparam int ST_PSENSE = 2;
   localparam int ST_INTTRUE = 3;
   localparam int ST_FIRST = 4;
   localparam logic [7:0] CC_RESET = 8'h00;
   localparam logic [7:0] IC_RESET = 8'h00;
   localparam logic [7:0] ST_RESET = 8'h10;
   localparam logic [7:0] ST_KEEP_MASK = 8'h04;
   // Clock out selection codes
   localparam logic [2:0] CO_DISABLE = 3'h4;
   localparam logic [2:0] CO_1HZ = 3'h5;
   localparam logic [2:0] CO_2HZ = 3'h6;
   localparam logic [2:0] CO_LINE = 3'h7;
   // Crystal select code for 32 kHz, 4 MHz and 2 MHz
   localparam logic [1:0] XS_4M = 2'h0;
   localparam logic [1:0] XS_2M = 2'h1;
   localparam logic [1:0] XS_32K = 2'h3;
   // Timing, core clock 10 MHz
   localparam int CLK_HZ = 10_000_000;
   localparam real PS_MIN_MS = 2.68;
   localparam real PS_MAX_MS = 4.64;
   localparam int PS_CYC = int'(PS_MIN_MS * real'(CLK_HZ) / 1000.0 + 0.999);
   localparam real AL_32K_US = 30.5;
   localparam real AL_2M_US = 15.3;
   localparam real AL_4M_US = 7.6;
   localparam int AL_32K_CYC = int'(AL_32K_US * real'(CLK_HZ) / 1.0e6 + 0.999);
   localparam int AL_2M_CYC = int'(AL_2M_US * real'(CLK_HZ) / 1.0e6 + 0.999);
   localparam int AL_4M_CYC = int'(AL_4M_US * real'(CLK_HZ) / 1.0e6 + 0.999);

   typedef struct packed {
      logic alarm_match;
      logic periodic_tick;
   } rpc_events_t;

   typedef struct packed {
      logic wr_cc;
      logic wr_ic;
      logic rd_status;
      logic [7:0] wdata;
   } rpc_regacc_t;
endpackage : rpc_pkg

// ===== design/rpc_sync.sv
`timescale 1ns/1ps
module rpc_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   // Two stages; first stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : rpc_sync

// ===== design/rpc_top.sv
`timescale 1ns/1ps
// Behaviour
// - Clock-out frequency chosen by clock control bits 2..0; seven rates or low.
// - Selected clock-out toggles at 50% duty, except 2Hz under 50Hz mains.
// - Clock-out is held low from power-down start until power-down ends.
// - Clock and interrupt control readable and writable; status read-only.
// - Mains power-fail sensing active only while interrupt control bit 5 set.
// - After mains transitions stop, wait 2.68-4.64ms, interrupt, set sense flag.
// - Host writes interrupt control bit 6; device drives supply enable low.
// - Power-down drives host reset low and disables serial interface.
// - Alarm, periodic or power-sense interrupt ends power-down.
// - Rail monitor recovery ends power-down in either supply mode.
// - Rail recovery restores supply enable, clock-out and host reset high.
// - Interrupt line pulled low on power fail, alarm match or periodic event.
// - Alarm flag and interrupt delayed 30.5us, 15.3us or 7.6us by crystal.
// - Interrupt line stays low until status read releases it.
// - Chip enable low holds serial interface logic in reset.
// - Power-on reset clears controls and dividers, sets first-power flag.
// - Rail monitor level latched after reset picks single-supply or backup mode.
// - Clock control bit 6 selects mains as time base while interrupt control bit 5 is clear.
// - Series oscillator resistor in only at 32kHz; 4MHz default after reset.
// - Status read clears every status bit except the power-sense flag.
module rpc_top #(
   parameter int PS_DELAY_CYC = rpc_pkg::PS_CYC,
   parameter int DIV_W = 6
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic CHIP_ENABLE_I,
   input wire rpc_pkg::rpc_regacc_t REG_ACC_I,
   input wire rpc_pkg::rpc_events_t EVENTS_I,
   input wire logic CRYSTAL_SOURCE_TICK_I,
   input wire logic LINE_TICK_I,
   input wire logic HZ1_TICK_I,
   input wire logic HZ2_TICK_I,
   input wire logic LINE_I,
   input wire logic SYSTEM_RAIL_MONITOR_I,
   output logic [7:0] CLOCK_CTRL_O,
   output logic [7:0] INT_CTRL_O,
   output logic [7:0] STATUS_O,
   output logic CLK_OUT_O,
   output logic SUPPLY_ENABLE_OUTPUT_O,
   output logic HOST_RESET_OUTPUT_O,
   output logic HOST_RESET_OUTPUT_OE_N_O,
   output logic INT_O,
   output logic INT_OE_N_O,
   output logic SERIAL_ENABLE_O,
   output logic LINE_TIMEBASE_O,
   output logic SERIES_RES_O,
   output logic BACKUP_MODE_O
);
   ////////////////////////////////////////////////////////////////////////
   logic line_s;
   logic rail_s;
   logic [7:0] cc;
   logic [7:0] ic;
   logic [7:0] st;
   logic pdown;
   logic mode_done;
   logic backup;
   logic serial_on;
   logic acc_ok;
   logic ps_fire;
   logic al_fire;
   logic any_int;
   logic rail_up;
   logic rail_fell;
   logic rail_prev;

   rpc_sync #(.W(2)) u_sync (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .d_i({LINE_I, SYSTEM_RAIL_MONITOR_I}),
      .q_o({line_s, rail_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // Serial side gating
   assign serial_on = CHIP_ENABLE_I && !pdown;
   assign acc_ok = serial_on;

   // Control registers, cleared by reset
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cc <= rpc_pkg::CC_RESET;
      end else if (acc_ok && REG_ACC_I.wr_cc) begin
         cc <= REG_ACC_I.wdata;
      end
   end

   logic next_pd_bit;
   always_comb begin
      next_pd_bit = ic[rpc_pkg::IC_PDOWN];
      if (acc_ok && REG_ACC_I.wr_ic) begin
         next_pd_bit = REG_ACC_I.wdata[rpc_pkg::IC_PDOWN];
      end
      if (any_int || rail_up) begin
         next_pd_bit = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ic <= rpc_pkg::IC_RESET;
      end else begin
         if (acc_ok && REG_ACC_I.wr_ic) begin
            ic <= REG_ACC_I.wdata;
         end
         ic[rpc_pkg::IC_PDOWN] <= next_pd_bit;
      end
   end
   assign pdown = ic[rpc_pkg::IC_PDOWN];

   ////////////////////////////////////////////////////////////////////////
   // Mode latch once the synchroniser holds the real rail level
   // Synchroniser is cleared by reset, so its first two samples are not the pin
   localparam logic [1:0] SETTLE_CYC = 2'h2;
   logic [1:0] settle;
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         settle <= '0;
         mode_done <= 1'b0;
         backup <= 1'b0;
      end else if (!mode_done) begin
         if (settle == SETTLE_CYC) begin
            mode_done <= 1'b1;
            backup <= !rail_s;
         end else begin
            settle <= settle + 2'h1;
         end
      end
   end

   // Rail recovery: backup waits for rise, single supply for low then high
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rail_prev <= 1'b0;
         rail_fell <= 1'b0;
      end else begin
         rail_prev <= rail_s;
         if (!pdown || rail_up) begin
            rail_fell <= 1'b0;
         end else if (!rail_s) begin
            rail_fell <= 1'b1;
         end
      end
   end
   // Backup mode rises from a startup low too, since disabled outputs wait
   assign rail_up = mode_done && rail_s && !rail_prev
                    && (pdown ? (rail_fell || backup) : 1'b0);

   ////////////////////////////////////////////////////////////////////////
   // Power sense: no mains edge for the window means failure
   logic [$clog2(rpc_pkg::PS_CYC*2+1)-1:0] ps_cnt;
   logic line_prev;
   logic ps_armed;
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ps_cnt <= '0;
         line_prev <= 1'b0;
         ps_armed <= 1'b0;
      end else begin
         line_prev <= line_s;
         if (!ic[rpc_pkg::IC_PSENSE]) begin
            ps_cnt <= '0;
            ps_armed <= 1'b1;
         end else if (line_s != line_prev) begin
            ps_cnt <= '0;
         end else if (ps_armed && ps_cnt == $bits(ps_cnt)'(PS_DELAY_CYC - 1)) begin
            ps_armed <= 1'b0;
         end else if (ps_armed) begin
            ps_cnt <= ps_cnt + 1'b1;
         end
      end
   end
   assign ps_fire = ic[rpc_pkg::IC_PSENSE] && ps_armed && (line_s == line_prev)
                    && ps_cnt == $bits(ps_cnt)'(PS_DELAY_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // Alarm delay by crystal selection
   // Nine bits: the 32kHz delay is over 255 core cycles
   logic [8:0] al_cnt;
   logic al_busy;
   logic [8:0] al_len;
   always_comb begin
      case (cc[rpc_pkg::CC_XSEL_LSB +: 2])
         rpc_pkg::XS_32K: al_len = 9'(rpc_pkg::AL_32K_CYC);
         rpc_pkg::XS_2M: al_len = 9'(rpc_pkg::AL_2M_CYC);
         rpc_pkg::XS_4M: al_len = 9'(rpc_pkg::AL_4M_CYC);
         default: al_len = 9'(rpc_pkg::AL_2M_CYC);
      endcase
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         al_cnt <= '0;
         al_busy <= 1'b0;
      end else if (!al_busy) begin
         if (EVENTS_I.alarm_match && ic[rpc_pkg::IC_ALARM]) begin
            al_busy <= 1'b1;
            al_cnt <= 9'h001;
         end
      end else if (al_cnt == al_len) begin
         al_busy <= 1'b0;
      end else begin
         al_cnt <= al_cnt + 9'h001;
      end
   end
   assign al_fire = al_busy && al_cnt == al_len;

   logic per_fire;
   assign per_fire = EVENTS_I.periodic_tick
                     && ic[rpc_pkg::IC_PER_LSB +: rpc_pkg::IC_PER_W] != 4'h0;
   assign any_int = per_fire || al_fire || ps_fire;

   ////////////////////////////////////////////////////////////////////////
   // Status: set wins over read clear; sense flag survives reads
   logic [7:0] next_st;
   always_comb begin
      next_st = st;
      if (REG_ACC_I.rd_status && acc_ok) begin
         next_st = st & rpc_pkg::ST_KEEP_MASK;
      end
      if (per_fire) next_st[rpc_pkg::ST_CLOCK] = 1'b1;
      if (al_fire) next_st[rpc_pkg::ST_ALARM] = 1'b1;
      if (ps_fire) next_st[rpc_pkg::ST_PSENSE] = 1'b1;
      if (any_int) next_st[rpc_pkg::ST_INTTRUE] = 1'b1;
   end
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st <= rpc_pkg::ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Interrupt line: held low until status read, new event wins
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         INT_O <= 1'b0;
         INT_OE_N_O <= 1'b1;
      end else if (any_int) begin
         INT_OE_N_O <= 1'b0;
      end else if (REG_ACC_I.rd_status && acc_ok) begin
         INT_OE_N_O <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock out: divided crystal enables, line and 1/2 Hz ticks
   logic [DIV_W-1:0] div;
   logic co;
   logic co_tick;
   logic co_low2;
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         div <= '0;
      end else if (CRYSTAL_SOURCE_TICK_I) begin
         div <= div + 1'b1;
      end
   end
   always_comb begin
      co_tick = 1'b0;
      case (cc[rpc_pkg::CC_CLKOUT_LSB +: rpc_pkg::CC_CLKOUT_W])
         3'h0: co_tick = CRYSTAL_SOURCE_TICK_I;
         3'h1: co_tick = CRYSTAL_SOURCE_TICK_I && div[0] == 1'b1;
         3'h2: co_tick = CRYSTAL_SOURCE_TICK_I && div[1:0] == 2'h3;
         3'h3: co_tick = CRYSTAL_SOURCE_TICK_I && div[2:0] == 3'h7;
         rpc_pkg::CO_1HZ: co_tick = HZ1_TICK_I;
         rpc_pkg::CO_2HZ: co_tick = HZ2_TICK_I;
         rpc_pkg::CO_LINE: co_tick = cc[rpc_pkg::CC_LINE] ? LINE_TICK_I
                                     : (CRYSTAL_SOURCE_TICK_I && div == '1);
         default: co_tick = 1'b0;
      endcase
   end
   // 2Hz from a 50Hz base cannot split evenly; output pulses one line period high
   assign co_low2 = cc[rpc_pkg::CC_LINE] && cc[rpc_pkg::CC_HZ50]
                    && cc[2:0] == rpc_pkg::CO_2HZ;
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         co <= 1'b0;
      end else if (pdown || cc[2:0] == rpc_pkg::CO_DISABLE) begin
         co <= 1'b0;
      end else if (co_low2) begin
         co <= HZ2_TICK_I ? 1'b1 : (LINE_TICK_I ? 1'b0 : co);
      end else if (co_tick) begin
         co <= !co;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs registered; disabled while powered down or not yet up in backup
   logic outs_on;
   logic backup_wait;
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         backup_wait <= 1'b1;
      end else if (mode_done && rail_s) begin
         backup_wait <= 1'b0;
      end else if (mode_done && backup && !rail_s) begin
         backup_wait <= 1'b1;
      end
   end
   assign outs_on = !pdown && !(backup_wait && mode_done && backup);

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CLOCK_CTRL_O <= rpc_pkg::CC_RESET;
         INT_CTRL_O <= rpc_pkg::IC_RESET;
         STATUS_O <= rpc_pkg::ST_RESET;
         CLK_OUT_O <= 1'b0;
         SUPPLY_ENABLE_OUTPUT_O <= 1'b0;
         HOST_RESET_OUTPUT_O <= 1'b0;
         HOST_RESET_OUTPUT_OE_N_O <= 1'b0;
         SERIAL_ENABLE_O <= 1'b0;
         LINE_TIMEBASE_O <= 1'b0;
         SERIES_RES_O <= 1'b0;
         BACKUP_MODE_O <= 1'b0;
      end else begin
         CLOCK_CTRL_O <= cc;
         INT_CTRL_O <= ic;
         STATUS_O <= st;
         CLK_OUT_O <= co && outs_on;
         SUPPLY_ENABLE_OUTPUT_O <= outs_on && mode_done;
         HOST_RESET_OUTPUT_OE_N_O <= outs_on && mode_done;
         SERIAL_ENABLE_O <= serial_on;
         // Mains tick only used when sensing is off
         LINE_TIMEBASE_O <= cc[rpc_pkg::CC_LINE] && !ic[rpc_pkg::IC_PSENSE];
         SERIES_RES_O <= cc[rpc_pkg::CC_XSEL_LSB +: 2] == rpc_pkg::XS_32K;
         BACKUP_MODE_O <= backup;
      end
   end
endmodule : rpc_top

// ===== testbench/rpc_top_properties.sv
`timescale 1ns/1ps
module rpc_top_properties (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic CHIP_ENABLE_I,
   input wire rpc_pkg::rpc_regacc_t REG_ACC_I,
   input wire rpc_pkg::rpc_events_t EVENTS_I,
   input wire logic [7:0] CLOCK_CTRL_O,
   input wire logic [7:0] INT_CTRL_O,
   input wire logic [7:0] STATUS_O,
   input wire logic CLK_OUT_O,
   input wire logic SUPPLY_ENABLE_OUTPUT_O,
   input wire logic HOST_RESET_OUTPUT_OE_N_O,
   input wire logic INT_OE_N_O,
   input wire logic SERIAL_ENABLE_O,
   input wire logic LINE_TIMEBASE_O,
   input wire logic SERIES_RES_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   logic pd;
   assign pd = INT_CTRL_O[rpc_pkg::IC_PDOWN];
   ////////////////////////////////////////
   // Quiet read: no event and no sense that could set a flag again
   sequence s_read;
      REG_ACC_I.rd_status && CHIP_ENABLE_I && !pd && EVENTS_I == '0
         && !INT_CTRL_O[rpc_pkg::IC_PSENSE];
   endsequence
   sequence s_quiet_read;
      s_read ##1 EVENTS_I == '0;
   endsequence
   sequence s_cfg;
      $stable(CLOCK_CTRL_O) ##1 $stable(CLOCK_CTRL_O);
   endsequence
   property p_pd_clk;
      pd |-> !CLK_OUT_O;
   endproperty
   a_pd_clk: assert property (p_pd_clk) else $error("clock out high in power-down");
   property p_pd_pins;
      pd |-> !SUPPLY_ENABLE_OUTPUT_O && !HOST_RESET_OUTPUT_OE_N_O && !SERIAL_ENABLE_O;
   endproperty
   a_pd_pins: assert property (p_pd_pins) else $error("power-down pins wrong");
   property p_ce_off;
      !CHIP_ENABLE_I |=> !SERIAL_ENABLE_O;
   endproperty
   a_ce_off: assert property (p_ce_off) else $error("serial on with enable low");
   property p_cc_wr;
      REG_ACC_I.wr_cc && CHIP_ENABLE_I && !pd |-> ##2 CLOCK_CTRL_O == $past(REG_ACC_I.wdata, 2);
   endproperty
   a_cc_wr: assert property (p_cc_wr) else $error("clock control write lost");
   property p_int_rel;
      !INT_OE_N_O ##0 s_read |=> INT_OE_N_O;
   endproperty
   a_int_rel: assert property (p_int_rel) else $error("interrupt kept after read");
   property p_int_cause;
      $rose(INT_OE_N_O) |-> $past(REG_ACC_I.rd_status) && $past(CHIP_ENABLE_I);
   endproperty
   a_int_cause: assert property (p_int_cause) else $error("interrupt freed unread");
   property p_st_clr;
      s_quiet_read |=> (STATUS_O & ~rpc_pkg::ST_KEEP_MASK) == 8'h00;
   endproperty
   a_st_clr: assert property (p_st_clr) else $error("status not cleared by read");
   property p_xsel;
      s_cfg |-> SERIES_RES_O == (CLOCK_CTRL_O[5:4] == rpc_pkg::XS_32K)
         && LINE_TIMEBASE_O == CLOCK_CTRL_O[rpc_pkg::CC_LINE];
   endproperty
   a_xsel: assert property (p_xsel) else $error("resistor or time base wrong");
   property p_clk_dis;
      s_cfg ##0 CLOCK_CTRL_O[2:0] == rpc_pkg::CO_DISABLE |-> !CLK_OUT_O;
   endproperty
   a_clk_dis: assert property (p_clk_dis) else $error("disabled clock out high");
endmodule : rpc_top_properties

// ===== testbench/rpc_supply_model.sv
`timescale 1ns/1ps
module rpc_supply_model (
   input wire logic clk_i,
   input wire logic line_run_i,
   input wire logic rail_up_i,
   output logic line_o,
   output logic rail_o
);
   logic [2:0] cnt = 3'h0;
   logic line_q = 1'b0;
   // Detector output freezes once AC stops, as a dead mains would
   always @(negedge clk_i) begin
      cnt <= cnt + 3'h1;
      if (line_run_i && cnt == 3'h7) begin
         line_q <= ~line_q;
      end
   end
   assign line_o = line_q;
   assign rail_o = rail_up_i;
endmodule : rpc_supply_model

// ===== testbench/rpc_top_tb.sv
`timescale 1ns/1ps
module rpc_top_tb;
   localparam int PS = 50;
   localparam logic [2:0] WCC = 3'h4;
   localparam logic [2:0] WIC = 3'h2;
   localparam logic [2:0] RD = 3'h1;
   logic clk = 0;
   logic rst = 1;
   logic ce = 1;
   rpc_pkg::rpc_regacc_t acc = '0;
   rpc_pkg::rpc_events_t ev = '0;
   logic xt = 0;
   logic hz1 = 0;
   logic line_run = 1;
   logic rail_up = 1;
   logic line, rail, clko, se, hr_oe_n, irq_oe_n, ser, ltb, sres, bkm, v;
   logic [7:0] cc, ic, st;
   int fails = 0;
   int tests_run = 0;
   int c, al;
   always #50 clk = ~clk;
   always @(negedge clk) xt <= ~xt;
   rpc_supply_model rpc_supply_model_i (.clk_i(clk), .line_run_i(line_run),
      .rail_up_i(rail_up), .line_o(line), .rail_o(rail));
   rpc_top #(.PS_DELAY_CYC(PS)) rpc_top_i (.CORE_CLK_I(clk), .RST_I(rst),
      .CHIP_ENABLE_I(ce), .REG_ACC_I(acc), .EVENTS_I(ev), .CRYSTAL_SOURCE_TICK_I(xt),
      .LINE_TICK_I(1'b0), .HZ1_TICK_I(hz1), .HZ2_TICK_I(1'b0), .LINE_I(line),
      .SYSTEM_RAIL_MONITOR_I(rail), .CLOCK_CTRL_O(cc), .INT_CTRL_O(ic), .STATUS_O(st),
      .CLK_OUT_O(clko), .SUPPLY_ENABLE_OUTPUT_O(se), .HOST_RESET_OUTPUT_O(),
      .HOST_RESET_OUTPUT_OE_N_O(hr_oe_n), .INT_O(), .INT_OE_N_O(irq_oe_n),
      .SERIAL_ENABLE_O(ser), .LINE_TIMEBASE_O(ltb), .SERIES_RES_O(sres),
      .BACKUP_MODE_O(bkm));
   ////////////////////////////////////////
   task chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   task w(input int n);
      repeat (n) @(negedge clk);
   endtask : w
   task rw(input logic [2:0] k, input logic [7:0] d);
      @(negedge clk);
      acc = {k, d};
      @(negedge clk);
      acc = '0;
      w(2);
   endtask : rw
   task pulse(input logic [1:0] e);
      @(negedge clk);
      ev = e;
      @(negedge clk);
      ev = '0;
   endtask : pulse
   task wint;
      c = 0;
      while (irq_oe_n !== 1'b0 && c < 1000) begin
         @(negedge clk);
         c++;
      end
   endtask : wint
   task close_out;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////
   task t_reset;
      chk(cc, rpc_pkg::CC_RESET);
      chk(ic, rpc_pkg::IC_RESET);
      chk(st, rpc_pkg::ST_RESET);
      chk(irq_oe_n, 1);
      chk(bkm, 0);
      chk(se, 1);
      chk(sres, 0);
   endtask : t_reset
   task t_regs;
      rw(WCC, 8'h74);
      chk(cc, 8'h74);
      w(2);
      chk(sres, 1);
      chk(ltb, 1);
      chk(clko, 0);
      rw(WIC, 8'h0c);
      chk(ic, 8'h0c);
      ce = 0;
      w(2);
      chk(ser, 0);
      rw(WCC, 8'h00);
      ce = 1;
      chk(cc, 8'h74);
   endtask : t_regs
   task t_clk1;
      rw(WCC, 8'h85);
      repeat (5) begin
         v = clko;
         @(negedge clk);
         hz1 = 1;
         @(negedge clk);
         hz1 = 0;
         w(3);
         chk(clko, !v);
         w(10);
         chk(clko, !v);
      end
   endtask : t_clk1
   task t_pdown;
      rw(WIC, 8'h41);
      chk(se, 0);
      chk(hr_oe_n, 0);
      chk(ser, 0);
      chk(clko, 0);
      rw(WCC, 8'h00);
      chk(cc, 8'h85);
      pulse(2'b01);
      w(2);
      chk(se, 1);
      chk(hr_oe_n, 1);
      chk(ic, 8'h01);
      chk(irq_oe_n, 0);
      chk(st & 8'h09, 8'h09);
      rw(RD, 8'h00);
      chk(irq_oe_n, 1);
      chk(st, 8'h00);
   endtask : t_pdown
   task t_rail;
      rw(WIC, 8'h40);
      rail_up = 0;
      w(6);
      rail_up = 1;
      w(6);
      chk(se, 1);
      chk(ic[6], 0);
      chk(hr_oe_n, 1);
      chk(ser, 1);
   endtask : t_rail
   task t_alarm;
      for (int i = 0; i < 2; i++) begin
         rw(WCC, i ? 8'h30 : 8'h00);
         rw(WIC, 8'h10);
         pulse(2'b10);
         wint;
         al = i ? rpc_pkg::AL_32K_CYC : rpc_pkg::AL_4M_CYC;
         chk(c >= al - 1 && c <= al + 4, 1);
         w(1);
         chk(st[1], 1);
         rw(RD, 8'h00);
         chk(irq_oe_n, 1);
      end
   endtask : t_alarm
   task t_psense;
      rw(WCC, 8'h04);
      rw(WIC, 8'h00);
      line_run = 0;
      w(80);
      chk(irq_oe_n, 1);
      line_run = 1;
      rw(WIC, 8'h20);
      w(80);
      chk(irq_oe_n, 1);
      line_run = 0;
      wint;
      chk(c >= PS - 9 && c <= PS + 8, 1);
      w(1);
      chk(st[2], 1);
      rw(RD, 8'h00);
      chk(irq_oe_n, 1);
      chk(st[2], 1);
      rw(WIC, 8'h00);
      rw(WIC, 8'h20);
      w(80);
      chk(irq_oe_n, 0);
   endtask : t_psense
   ////////////////////////////////////////
   initial begin
      w(4);
      rst = 0;
      // Mode settles three edges after release, outputs one edge later
      w(4);
      t_reset;
      t_regs;
      t_clk1;
      t_pdown;
      t_rail;
      t_alarm;
      t_psense;
      close_out;
   end
   // Whole run is under a thousand cycles; ten thousand means a hang
   initial begin
      #1_000_000;
      fails++;
      close_out;
   end
endmodule : rpc_top_tb
bind rpc_top rpc_top_properties rpc_top_properties_i (.CORE_CLK_I, .RST_I,
   .CHIP_ENABLE_I, .REG_ACC_I, .EVENTS_I, .CLOCK_CTRL_O, .INT_CTRL_O, .STATUS_O,
   .CLK_OUT_O, .SUPPLY_ENABLE_OUTPUT_O, .HOST_RESET_OUTPUT_OE_N_O, .INT_OE_N_O,
   .SERIAL_ENABLE_O, .LINE_TIMEBASE_O, .SERIES_RES_O);
